// *** hdl/usrx_params.svh ***
// Offsets, field positions, reset values and timing counts of the receive block
// Assumes inclusion by bare name from the clock generator and top design modules
`ifndef USRX_PARAMS_SVH
`define USRX_PARAMS_SVH

`define USRX_OFF_RX_DATA 8'h00
`define USRX_OFF_CSR_A 8'h04
`define USRX_OFF_CSR_C 8'h08
`define USRX_OFF_BAUD 8'h0c
`define USRX_OFF_PIN_DIR 8'h10
`define USRX_OFF_IRQ_STAT 8'h14
`define USRX_OFF_IRQ_CLR 8'h18
`define USRX_OFF_IRQ_EN 8'h1c

`define USRX_A_RX_PEND 7
`define USRX_A_FE 4
`define USRX_A_DOR 3
`define USRX_A_U2X 1
`define USRX_A_RXB8 0

`define USRX_C_MSEL 6
`define USRX_C_NINE 1
`define USRX_C_RXEN 0

`define USRX_IRQ_RXC 0
`define USRX_IRQ_FE 1
`define USRX_IRQ_DOR 2
`define USRX_IRQ_W 3

`define USRX_RST_BAUD 12'h000
`define USRX_RST_IRQ_EN 3'h0

`define USRX_OSR_NORMAL 5'h10
`define USRX_OSR_DOUBLE 5'h08

`endif

// *** hdl/usrx_pkg.sv ***
// Types shared by the receive block modules
// Assumes usrx_params.svh is on the include path
package usrx_pkg;

    typedef enum logic [1:0] {
        USRX_CM_ASYNC  = 2'b00,
        USRX_CM_DOUBLE = 2'b01,
        USRX_CM_MASTER = 2'b11,
        USRX_CM_SLAVE  = 2'b10
    } usrx_clk_mode_type;

    typedef enum logic [1:0] {
        USRX_ST_IDLE  = 2'b00,
        USRX_ST_START = 2'b01,
        USRX_ST_DATA  = 2'b11,
        USRX_ST_STOP  = 2'b10
    } usrx_state_type;

    typedef struct packed {
        logic frame_err;
        logic overrun;
        logic ninth;
        logic [7:0] data;
    } usrx_entry_type;

    typedef struct packed {
        usrx_clk_mode_type mode;
        logic [11:0] baud;
        logic baud_wr;
    } usrx_clk_cfg_type;

endpackage

// *** hdl/usrx_fifo.sv ***
// Two-entry circular receive queue with registered head output
// Assumes push only when not full and pop only when not empty
`timescale 1ns/1ps
module usrx_fifo (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fill side
    input wire logic push,
    input wire usrx_pkg::usrx_entry_type din,
    output logic full,
    // Drain side
    input wire logic pop,
    output usrx_pkg::usrx_entry_type head_r,
    output logic empty
);
    usrx_pkg::usrx_entry_type mem_r [2];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] count_r;
    logic rd_ptr_nxt;
    logic do_push;
    logic do_pop;

    assign full = (count_r == 2'h2);
    assign empty = (count_r == 2'h0);
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign rd_ptr_nxt = do_pop ? ~rd_ptr_r : rd_ptr_r;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ent
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mem_r[i] <= '0;
                end else if (do_push && (wr_ptr_r == 1'(i))) begin
                    mem_r[i] <= din;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_r + {1'b0, do_push} - {1'b0, do_pop};
        end
    end

    // Head follows the entry that the read pointer will point at
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            head_r <= '0;
        end else if (do_push && (wr_ptr_r == rd_ptr_nxt)) begin
            head_r <= din;
        end else begin
            head_r <= mem_r[rd_ptr_nxt];
        end
    end
endmodule

// *** hdl/usrx_clkgen.sv ***
// Baud down-counter, master transfer clock and slave clock synchroniser
// Assumes the transfer clock pin is asynchronous to pclk
`timescale 1ns/1ps
`include "usrx_params.svh"
module usrx_clkgen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Configuration
    input wire usrx_pkg::usrx_clk_cfg_type cfg,
    // Transfer clock pin
    input wire logic xfer_clk_pin_i,
    output logic xfer_clk_pin_o,
    output logic xfer_clk_pin_oe,
    // Timing to the receiver
    output logic base_tick,
    output logic sync_sample
);
    logic [11:0] cnt_r;
    logic xck_out_r;
    logic xck_s1_r;
    logic xck_s2_r;
    logic xck_s3_r;
    logic is_master;
    logic is_slave;

    assign is_master = (cfg.mode == usrx_pkg::USRX_CM_MASTER);
    assign is_slave = (cfg.mode == usrx_pkg::USRX_CM_SLAVE);
    assign base_tick = (cnt_r == 12'h000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= `USRX_RST_BAUD;
        end else if (base_tick || cfg.baud_wr) begin
            cnt_r <= cfg.baud;
        end else begin
            cnt_r <= cnt_r - 12'h001;
        end
    end

    // Master clock is the base tick divided by two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xck_out_r <= 1'b0;
        end else if (!is_master) begin
            xck_out_r <= 1'b0;
        end else if (base_tick) begin
            xck_out_r <= ~xck_out_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xck_s1_r <= 1'b0;
            xck_s2_r <= 1'b0;
            xck_s3_r <= 1'b0;
        end else begin
            xck_s1_r <= xfer_clk_pin_i;
            xck_s2_r <= xck_s1_r;
            xck_s3_r <= xck_s2_r;
        end
    end

    assign xfer_clk_pin_o = xck_out_r;
    assign xfer_clk_pin_oe = is_master;
    // Data are sampled on the falling transfer clock edge
    always_comb begin
        if (is_master) begin
            sync_sample = base_tick && xck_out_r;
        end else if (is_slave) begin
            sync_sample = xck_s3_r && !xck_s2_r;
        end else begin
            sync_sample = 1'b0;
        end
    end
endmodule

// *** hdl/usrx_top.sv ***
// Receive buffering and clock-mode selection of a serial transceiver
// Assumes an APB master on pclk and a serial line asynchronous to pclk
`timescale 1ns/1ps
`include "usrx_params.svh"
module usrx_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial line
    input wire logic rxd,
    // Transfer clock pin
    input wire logic xfer_clk_pin_i,
    output logic xfer_clk_pin_o,
    output logic xfer_clk_pin_oe,
    // Interrupt
    output logic irq
);
    logic rxd_s1_r;
    logic rxd_s2_r;
    logic double_speed_bit_r;
    logic sync_mode_select_r;
    logic nine_en_r;
    logic rx_en_r;
    logic [11:0] baud_r;
    logic xfer_clk_pin_dir_r;
    logic [`USRX_IRQ_W-1:0] irq_stat_r;
    logic [`USRX_IRQ_W-1:0] irq_en_r;
    logic [`USRX_IRQ_W-1:0] irq_evt;
    logic [`USRX_IRQ_W-1:0] irq_clr;
    usrx_pkg::usrx_state_type state_r;
    usrx_pkg::usrx_clk_mode_type mode;
    usrx_pkg::usrx_clk_cfg_type clk_cfg;
    usrx_pkg::usrx_entry_type hold_r;
    usrx_pkg::usrx_entry_type head_r;
    logic hold_valid_r;
    logic ovr_pend_r;
    logic [8:0] shift_r;
    logic [3:0] bit_idx_r;
    logic [4:0] cnt_r;
    logic [4:0] osr;
    logic is_sync;
    logic base_tick;
    logic sync_sample;
    logic wr_en;
    logic rd_en;
    logic pop;
    logic push;
    logic full;
    logic empty;
    logic start_seen;
    logic bit_strobe;
    logic frame_done;
    logic lose_held;
    logic [3:0] last_idx;
    logic [31:0] rd_mux;
    logic addr_ok;

    // Clock mode from the three selection bits
    always_comb begin
        if (sync_mode_select_r) begin
            mode = xfer_clk_pin_dir_r ? usrx_pkg::USRX_CM_MASTER
                                      : usrx_pkg::USRX_CM_SLAVE;
        end else begin
            mode = double_speed_bit_r ? usrx_pkg::USRX_CM_DOUBLE
                                      : usrx_pkg::USRX_CM_ASYNC;
        end
    end

    assign is_sync = sync_mode_select_r;
    assign osr = (mode == usrx_pkg::USRX_CM_DOUBLE) ? `USRX_OSR_DOUBLE
                                                    : `USRX_OSR_NORMAL;
    assign clk_cfg.mode = mode;
    assign clk_cfg.baud = baud_r;
    assign clk_cfg.baud_wr = wr_en && (paddr == `USRX_OFF_BAUD);

    usrx_clkgen u_clkgen (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(clk_cfg),
        .xfer_clk_pin_i(xfer_clk_pin_i),
        .xfer_clk_pin_o(xfer_clk_pin_o),
        .xfer_clk_pin_oe(xfer_clk_pin_oe),
        .base_tick(base_tick),
        .sync_sample(sync_sample)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_s1_r <= 1'b1;
            rxd_s2_r <= 1'b1;
        end else begin
            rxd_s1_r <= rxd;
            rxd_s2_r <= rxd_s1_r;
        end
    end

    // APB access decode, zero wait states
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pop = rd_en && (paddr == `USRX_OFF_RX_DATA);

    always_comb begin
        rd_mux = 32'h0000_0000;
        addr_ok = 1'b1;
        case (paddr)
            `USRX_OFF_RX_DATA: rd_mux[7:0] = head_r.data;
            `USRX_OFF_CSR_A: begin
                rd_mux[`USRX_A_RX_PEND] = !empty;
                rd_mux[`USRX_A_FE] = head_r.frame_err;
                rd_mux[`USRX_A_DOR] = head_r.overrun;
                rd_mux[`USRX_A_U2X] = double_speed_bit_r;
                rd_mux[`USRX_A_RXB8] = head_r.ninth;
            end
            `USRX_OFF_CSR_C: begin
                rd_mux[`USRX_C_MSEL] = sync_mode_select_r;
                rd_mux[`USRX_C_NINE] = nine_en_r;
                rd_mux[`USRX_C_RXEN] = rx_en_r;
            end
            `USRX_OFF_BAUD: rd_mux[11:0] = baud_r;
            `USRX_OFF_PIN_DIR: rd_mux[0] = xfer_clk_pin_dir_r;
            `USRX_OFF_IRQ_STAT: rd_mux[`USRX_IRQ_W-1:0] = irq_stat_r;
            `USRX_OFF_IRQ_CLR: rd_mux = 32'h0000_0000;
            `USRX_OFF_IRQ_EN: rd_mux[`USRX_IRQ_W-1:0] = irq_en_r;
            default: addr_ok = 1'b0;
        endcase
    end

    assign prdata = rd_en ? rd_mux : 32'h0000_0000;
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            double_speed_bit_r <= 1'b0;
            sync_mode_select_r <= 1'b0;
            nine_en_r <= 1'b0;
            rx_en_r <= 1'b0;
            baud_r <= `USRX_RST_BAUD;
            xfer_clk_pin_dir_r <= 1'b0;
            irq_en_r <= `USRX_RST_IRQ_EN;
        end else if (wr_en) begin
            case (paddr)
                `USRX_OFF_CSR_A: double_speed_bit_r <= pwdata[`USRX_A_U2X];
                `USRX_OFF_CSR_C: begin
                    sync_mode_select_r <= pwdata[`USRX_C_MSEL];
                    nine_en_r <= pwdata[`USRX_C_NINE];
                    rx_en_r <= pwdata[`USRX_C_RXEN];
                end
                `USRX_OFF_BAUD: baud_r <= pwdata[11:0];
                `USRX_OFF_PIN_DIR: xfer_clk_pin_dir_r <= pwdata[0];
                `USRX_OFF_IRQ_EN: irq_en_r <= pwdata[`USRX_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Receiver bit timing
    assign start_seen = rx_en_r && (state_r == usrx_pkg::USRX_ST_IDLE) && !rxd_s2_r
        && (is_sync ? sync_sample : 1'b1);
    assign bit_strobe = is_sync ? sync_sample
        : (base_tick && (cnt_r == osr - 5'h01));
    assign last_idx = nine_en_r ? 4'h8 : 4'h7;
    assign frame_done = (state_r == usrx_pkg::USRX_ST_STOP) && bit_strobe;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= usrx_pkg::USRX_ST_IDLE;
            cnt_r <= 5'h00;
            bit_idx_r <= 4'h0;
            shift_r <= 9'h000;
        end else if (!rx_en_r) begin
            state_r <= usrx_pkg::USRX_ST_IDLE;
            cnt_r <= 5'h00;
        end else begin
            if (!is_sync && base_tick) begin
                cnt_r <= (cnt_r == osr - 5'h01) ? 5'h00 : cnt_r + 5'h01;
            end
            case (state_r)
                usrx_pkg::USRX_ST_IDLE: begin
                    bit_idx_r <= 4'h0;
                    if (start_seen) begin
                        cnt_r <= 5'h00;
                        state_r <= is_sync ? usrx_pkg::USRX_ST_DATA
                                           : usrx_pkg::USRX_ST_START;
                    end
                end
                usrx_pkg::USRX_ST_START: begin
                    // Confirm the start bit at its middle, then realign
                    if (base_tick && (cnt_r == (osr >> 1) - 5'h01)) begin
                        cnt_r <= 5'h00;
                        state_r <= rxd_s2_r ? usrx_pkg::USRX_ST_IDLE
                                            : usrx_pkg::USRX_ST_DATA;
                    end
                end
                usrx_pkg::USRX_ST_DATA: begin
                    if (bit_strobe) begin
                        shift_r[bit_idx_r] <= rxd_s2_r;
                        bit_idx_r <= bit_idx_r + 4'h1;
                        if (bit_idx_r == last_idx) begin
                            state_r <= usrx_pkg::USRX_ST_STOP;
                        end
                    end
                end
                usrx_pkg::USRX_ST_STOP: begin
                    if (bit_strobe) begin
                        state_r <= usrx_pkg::USRX_ST_IDLE;
                    end
                end
                default: state_r <= usrx_pkg::USRX_ST_IDLE;
            endcase
        end
    end

    // Third buffer level and overrun
    assign push = hold_valid_r && !full;
    assign lose_held = start_seen && hold_valid_r && full;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_valid_r <= 1'b0;
            hold_r <= '0;
            ovr_pend_r <= 1'b0;
        end else begin
            if (frame_done) begin
                hold_valid_r <= 1'b1;
                hold_r.data <= shift_r[7:0];
                hold_r.ninth <= nine_en_r && shift_r[8];
                hold_r.frame_err <= !rxd_s2_r;
                hold_r.overrun <= ovr_pend_r || lose_held;
                ovr_pend_r <= 1'b0;
            end else if (lose_held) begin
                hold_valid_r <= 1'b0;
                ovr_pend_r <= 1'b1;
            end else if (push) begin
                hold_valid_r <= 1'b0;
            end
        end
    end

    usrx_fifo u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .push(push),
        .din(hold_r),
        .full(full),
        .pop(pop),
        .head_r(head_r),
        .empty(empty)
    );

    // Sticky events, set wins over clear
    assign irq_evt[`USRX_IRQ_RXC] = push;
    assign irq_evt[`USRX_IRQ_FE] = push && hold_r.frame_err;
    assign irq_evt[`USRX_IRQ_DOR] = lose_held;
    assign irq_clr = (wr_en && (paddr == `USRX_OFF_IRQ_CLR))
        ? pwdata[`USRX_IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
        end
    end

    assign irq = |(irq_stat_r & irq_en_r);
endmodule

// *** verif/usrx_peer.sv ***
// Remote transceiver model driving the serial line and the slave transfer clock
// Assumes the bench calls its tasks one frame at a time
`timescale 1ns/1ps
module usrx_peer (
    // Toward the block
    output logic rxd,
    output logic xfer_clk_pin
);
    initial begin
        rxd = 1'b1;
        xfer_clk_pin = 1'b0;
    end

    // Start low, data LSB first, chosen stop level, then one idle bit
    task automatic send_async(input logic [8:0] d, input int nb, input logic stop, input int bt);
        rxd = 1'b0;
        #(bt);
        for (int i = 0; i < nb; i++) begin
            rxd = d[i];
            #(bt);
        end
        rxd = stop;
        #(bt);
        rxd = 1'b1;
        #(bt);
    endtask

    // Clock runs only within the frame; data changes on rise, held over fall
    task automatic send_sync(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            xfer_clk_pin = 1'b1;
            rxd = f[i];
            #80;
            xfer_clk_pin = 1'b0;
            #80;
        end
        rxd = 1'b1;
    endtask
endmodule

// *** verif/usrx_top_asserts.sv ***
// Concurrent checks on the ports of the receive block top
// Assumes binding to usrx_top with every port visible by name
`timescale 1ns/1ps
module usrx_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic rxd,
    input wire logic xfer_clk_pin_i,
    input wire logic xfer_clk_pin_o,
    input wire logic xfer_clk_pin_oe,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_rd(logic [7:0] a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    sequence s_mask_all;
        psel && penable && pwrite && paddr == 8'h1c && pwdata[2:0] == 3'h0;
    endsequence

    a_zero_wait: assert property (s_setup |=> pready)
        else $error("pready low in access phase");
    a_err_unmapped: assert property (psel && penable && paddr > 8'h1c |-> pslverr)
        else $error("unmapped access without error");
    a_err_mapped: assert property (psel && penable && paddr <= 8'h1c && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("mapped access flagged");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_rdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read access");
    a_data_width: assert property (s_rd(8'h00) |-> prdata[31:8] == 24'h0)
        else $error("data register upper bits set");
    a_status_bits: assert property (s_rd(8'h04) |-> prdata[31:8] == 24'h0 && prdata[6:5] == 2'b00
        && !prdata[2]) else $error("status reserved bits set");
    a_pin_async: assert property (s_rd(8'h08) ##0 !prdata[6] |-> !xfer_clk_pin_oe)
        else $error("pin driven in asynchronous mode");
    a_oe_cause: assert property ($changed(xfer_clk_pin_oe) |-> $past(psel && penable && pwrite
        && (paddr == 8'h08 || paddr == 8'h10))) else $error("pin direction changed unprompted");
    a_irq_masked: assert property (s_mask_all |=> !irq)
        else $error("interrupt with all sources masked");
    a_clr_reads0: assert property (s_rd(8'h18) |-> prdata == 32'h0)
        else $error("clear register reads nonzero");
endmodule

bind usrx_top usrx_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .xfer_clk_pin_i(xfer_clk_pin_i),
    .xfer_clk_pin_o(xfer_clk_pin_o), .xfer_clk_pin_oe(xfer_clk_pin_oe), .irq(irq));

// *** verif/usart_rx_buffer_and_clock_modes_bench.sv ***
// Self-checking bench for receive buffering and clock-mode selection
// Assumes the design, the peer model and the checker are compiled first
`timescale 1ns/1ps
module usart_rx_buffer_and_clock_modes_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic rxd, xfer_clk_pin, pin_i, pin_o, pin_oe, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int mismatches = 0;
    int compares = 0;

    assign pin_i = pin_oe ? pin_o : xfer_clk_pin;

    usrx_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .xfer_clk_pin_i(pin_i), .xfer_clk_pin_o(pin_o),
        .xfer_clk_pin_oe(pin_oe), .irq(irq));
    usrx_peer peer_u (.rxd(rxd), .xfer_clk_pin(xfer_clk_pin));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic conclude;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Return where outputs launched by the access edge have settled
        @(negedge pclk);
        if (pready !== 1'b1) begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask

    task automatic t_reset;
        logic [31:0] q;
        logic e;
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h18, 32'h0);
        wr(8'h1c, 32'h0);
        chk({31'h0, pin_oe}, 32'h0);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        wr(8'h1c, 32'h7);
        wr(8'h08, 32'h3);
    endtask

    // Two nine-bit characters, the second with a low stop bit
    task automatic t_fifo;
        peer_u.send_async(9'h1a5, 9, 1'b1, 320);
        peer_u.send_async(9'h03c, 9, 1'b0, 320);
        chk({31'h0, irq}, 32'h1);
        rd(8'h04, 32'h81);
        rd(8'h00, 32'ha5);
        rd(8'h04, 32'h90);
        rd(8'h00, 32'h3c);
        // Empty queue: pending bit clear, flags show the stale head entry
        rd(8'h04, 32'h1);
        rd(8'h14, 32'h3);
        wr(8'h18, 32'h7);
        rd(8'h14, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask

    // Third level held, then a start while full and held drops it
    task automatic t_third;
        wr(8'h08, 32'h1);
        peer_u.send_async(9'h011, 8, 1'b1, 320);
        peer_u.send_async(9'h022, 8, 1'b1, 320);
        peer_u.send_async(9'h033, 8, 1'b1, 320);
        rd(8'h00, 32'h11);
        rd(8'h00, 32'h22);
        rd(8'h04, 32'h80);
        rd(8'h00, 32'h33);
        rd(8'h04, 32'h0);
        peer_u.send_async(9'h044, 8, 1'b1, 320);
        peer_u.send_async(9'h055, 8, 1'b1, 320);
        peer_u.send_async(9'h066, 8, 1'b1, 320);
        peer_u.send_async(9'h077, 8, 1'b1, 320);
        rd(8'h00, 32'h44);
        rd(8'h04, 32'h80);
        rd(8'h00, 32'h55);
        rd(8'h04, 32'h88);
        rd(8'h00, 32'h77);
        rd(8'h14, 32'h5);
        wr(8'h18, 32'h7);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_double;
        wr(8'h04, 32'h2);
        peer_u.send_async(9'h05a, 8, 1'b1, 160);
        rd(8'h04, 32'h82);
        rd(8'h00, 32'h5a);
    endtask

    // Slave clock from the peer with the double-speed bit still set
    task automatic t_slave;
        wr(8'h10, 32'h0);
        wr(8'h08, 32'h41);
        chk({31'h0, pin_oe}, 32'h0);
        peer_u.send_sync(8'hc3);
        rd(8'h04, 32'h82);
        rd(8'h00, 32'hc3);
        wr(8'h08, 32'h1);
        wr(8'h10, 32'h1);
        rd(8'h08, 32'h1);
        chk({31'h0, pin_oe}, 32'h0);
    endtask

    // Master clock toggles once per base tick, every baud+1 cycles
    task automatic t_master;
        logic last;
        int t;
        wr(8'h0c, 32'h3);
        wr(8'h08, 32'h41);
        chk({31'h0, pin_oe}, 32'h1);
        t = 0;
        last = pin_o;
        repeat (64) begin
            @(posedge pclk);
            if (pin_o !== last) t++;
            last = pin_o;
        end
        chk(t, 32'd16);
        wr(8'h08, 32'h1);
        chk({31'h0, pin_oe}, 32'h0);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fifo();
        t_third();
        t_double();
        t_slave();
        t_master();
        conclude();
    end
endmodule
